// [src/abu_defs.vh]
// Register offsets, field positions, reset values and vectors of the address breakpoint unit
`ifndef ABU_DEFS_VH
`define ABU_DEFS_VH
`define ABU_OFF_STATUS_CONTROL   12'h000
`define ABU_OFF_ADDRESS_HIGH     12'h004
`define ABU_OFF_ADDRESS_LOW      12'h008
`define ABU_OFF_WAKEUP_STATUS    12'h00C
`define ABU_OFF_FLAG_CLEAR_CTRL  12'h010
`define ABU_BIT_MATCH_ENABLE     7
`define ABU_BIT_ACTIVE_FLAG      6
`define ABU_BIT_HALT_WAKEUP      1
`define ABU_BIT_FLAG_CLEAR_EN    7
`define ABU_RST_BYTE             8'h00
`define ABU_RST_ADDR             16'h0000
`define ABU_VECTOR_NORMAL        16'hFFFC
`define ABU_VECTOR_MONITOR       16'hFEFC
`define ABU_SOFT_INT_OPCODE      8'h83
`endif

// [src/abu_comparator.v]
// Registered 16-bit address comparator of the breakpoint unit
`timescale 1ns/10ps
module abu_comparator
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        enable,
   input  wire        addr_valid,
   input  wire [15:0] cpu_addr,
   input  wire [15:0] break_addr,
   output reg         match
);
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         match <= 1'b0;
      else
         match <= enable && addr_valid && (cpu_addr == break_addr);
   end
endmodule

// [src/abu_top.v]
// Address breakpoint unit: APB registers, match and forced break, halt control
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "abu_defs.vh"
module abu_top
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [15:0] cpu_addr,
   input  wire        cpu_addr_valid,
   input  wire        cpu_last_cycle,
   input  wire        cpu_break_taken,
   input  wire        cpu_rti_done,
   input  wire        monitor_mode,
   input  wire        wait_mode,
   input  wire        stop_mode,
   input  wire        test_high_voltage,
   output reg         break_request,
   output reg  [7:0]  soft_interrupt_opcode,
   output reg  [15:0] break_vector,
   output reg         break_state,
   output reg         timer_hold,
   output reg         watchdog_hold,
   output reg         halt_wakeup,
   output reg         status_clear_allow
);
   reg         brk_match_enable;
   reg         brk_active_flag;
   reg         halt_wakeup_flag;
   reg         flag_clear_in_halt_enable;
   reg  [7:0]  break_address_high;
   reg  [7:0]  break_address_low;
   reg  [1:0]  seq_state;
   reg  [1:0]  next_seq_state;
   wire [1:0]  async_in;
   wire [1:0]  sync_out;
   wire        mon_sync;
   wire        thv_sync;
   wire        sel_status_control;
   wire        sel_address_high;
   wire        sel_address_low;
   wire        sel_wakeup_status;
   wire        sel_flag_clear_ctrl;
   wire        break_event;
   wire        at_boundary;
   wire        match;
   wire        wr_en;
   wire        rd_en;
   wire        forced;
   wire        halted;
   reg  [31:0] next_rdata;
   reg         next_err;

   localparam  SEQ_IDLE  = 2'b00;
   localparam  SEQ_WAIT  = 2'b01;
   localparam  SEQ_REQ   = 2'b10;
   localparam  SEQ_BREAK = 2'b11;

   // monitor_mode and test_high_voltage pass a two-stage synchroniser, one per pin; wait_mode and stop_mode are used unsynchronised
   assign async_in = {test_high_voltage, monitor_mode};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_sync
         reg stage_one;
         reg stage_two;
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               stage_one <= 1'b0;
               stage_two <= 1'b0;
            end
            else
            begin
               stage_one <= async_in[gi];
               stage_two <= stage_one;
            end
         end
         assign sync_out[gi] = stage_two;
      end
   endgenerate

   assign mon_sync = sync_out[0];
   assign thv_sync = sync_out[1];

   // Comparator runs regardless of wait mode
   abu_comparator u_cmp
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .enable     (brk_match_enable),
      .addr_valid (cpu_addr_valid),
      .cpu_addr   (cpu_addr),
      .break_addr ({break_address_high, break_address_low}),
      .match      (match)
   );

   // Register selects and transfer qualifiers
   assign sel_status_control  = (paddr == `ABU_OFF_STATUS_CONTROL);
   assign sel_address_high    = (paddr == `ABU_OFF_ADDRESS_HIGH);
   assign sel_address_low     = (paddr == `ABU_OFF_ADDRESS_LOW);
   assign sel_wakeup_status   = (paddr == `ABU_OFF_WAKEUP_STATUS);
   assign sel_flag_clear_ctrl = (paddr == `ABU_OFF_FLAG_CLEAR_CTRL);
   assign wr_en       = psel && penable && pwrite && pready;
   assign rd_en       = psel && penable && !pwrite && pready;
   assign forced      = wr_en && sel_status_control && pwdata[`ABU_BIT_ACTIVE_FLAG];
   assign halted      = wait_mode || stop_mode;
   assign break_event = match || forced;
   assign at_boundary = cpu_last_cycle || halted;

   // Match enable of the status control register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         brk_match_enable <= 1'b0;
      else if (wr_en && sel_status_control)
         brk_match_enable <= pwdata[`ABU_BIT_MATCH_ENABLE];
   end

   // Break address, high byte
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         break_address_high <= `ABU_RST_BYTE;
      else if (wr_en && sel_address_high)
         break_address_high <= pwdata[7:0];
   end

   // Break address, low byte
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         break_address_low <= `ABU_RST_BYTE;
      else if (wr_en && sel_address_low)
         break_address_low <= pwdata[7:0];
   end

   // Flag clear enable, protected by default
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_clear_in_halt_enable <= 1'b0;
      else if (wr_en && sel_flag_clear_ctrl)
         flag_clear_in_halt_enable <= pwdata[`ABU_BIT_FLAG_CLEAR_EN];
   end

   // Active flag: a match or a write of one sets it; set wins over clear
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         brk_active_flag <= 1'b0;
      else if (break_event)
         brk_active_flag <= 1'b1;
      else if (wr_en && sel_status_control && !pwdata[`ABU_BIT_ACTIVE_FLAG])
         brk_active_flag <= 1'b0;
   end

   // Wakeup flag: break accepted while in wait or stop; set wins over clear
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         halt_wakeup_flag <= 1'b0;
      else if (cpu_break_taken && halted)
         halt_wakeup_flag <= 1'b1;
      else if (wr_en && sel_wakeup_status && !pwdata[`ABU_BIT_HALT_WAKEUP])
         halt_wakeup_flag <= 1'b0;
   end

   // Break sequencer: the request stands until the core takes the break
   always @*
   begin
      next_seq_state = seq_state;
      case (seq_state)
         SEQ_IDLE:
         begin
            if (cpu_break_taken)
               next_seq_state = SEQ_BREAK;
            else if (break_event && at_boundary)
               next_seq_state = SEQ_REQ;
            else if (break_event)
               next_seq_state = SEQ_WAIT;
         end
         SEQ_WAIT:
         begin
            if (cpu_break_taken)
               next_seq_state = SEQ_BREAK;
            else if (at_boundary)
               next_seq_state = SEQ_REQ;
         end
         SEQ_REQ:
         begin
            if (cpu_break_taken)
               next_seq_state = SEQ_BREAK;
         end
         SEQ_BREAK:
         begin
            if (cpu_rti_done)
               next_seq_state = SEQ_IDLE;
         end
         default:
            next_seq_state = SEQ_IDLE;
      endcase
   end

   // Registered outputs toward the CPU core
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_state             <= SEQ_IDLE;
         break_request         <= 1'b0;
         break_state           <= 1'b0;
         soft_interrupt_opcode <= `ABU_RST_BYTE;
         break_vector          <= `ABU_RST_ADDR;
      end
      else
      begin
         seq_state             <= next_seq_state;
         break_request         <= (next_seq_state == SEQ_REQ);
         break_state           <= (next_seq_state == SEQ_BREAK);
         soft_interrupt_opcode <= `ABU_SOFT_INT_OPCODE;
         break_vector          <= mon_sync ? `ABU_VECTOR_MONITOR : `ABU_VECTOR_NORMAL;
      end
   end

   // Side effects of the break request and break state on neighbouring blocks
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timer_hold <= 1'b0;
      else
         timer_hold <= break_state || cpu_break_taken;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         watchdog_hold <= 1'b0;
      else
         watchdog_hold <= (break_state || cpu_break_taken) && thv_sync;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         halt_wakeup <= 1'b0;
      else
         halt_wakeup <= break_request && halted;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_clear_allow <= 1'b1;
      else
         status_clear_allow <= !(break_state || cpu_break_taken) || flag_clear_in_halt_enable;
   end

   // APB read mux
   always @*
   begin
      next_rdata = 32'h00000000;
      next_err   = 1'b0;
      case (paddr)
         `ABU_OFF_STATUS_CONTROL:
         begin
            next_rdata[`ABU_BIT_MATCH_ENABLE] = brk_match_enable;
            next_rdata[`ABU_BIT_ACTIVE_FLAG]  = brk_active_flag;
         end
         `ABU_OFF_ADDRESS_HIGH:
            next_rdata[7:0] = break_address_high;
         `ABU_OFF_ADDRESS_LOW:
            next_rdata[7:0] = break_address_low;
         `ABU_OFF_WAKEUP_STATUS:
            next_rdata[`ABU_BIT_HALT_WAKEUP] = halt_wakeup_flag;
         `ABU_OFF_FLAG_CLEAR_CTRL:
            next_rdata[`ABU_BIT_FLAG_CLEAR_EN] = flag_clear_in_halt_enable;
         default:
            next_err = 1'b1;
      endcase
   end

   // One wait state: pready in second access cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= psel && penable && !pready;
   end

   // Error answer for an unmapped address, alongside pready
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr <= 1'b0;
      else
         pslverr <= psel && penable && !pready && next_err;
   end

   // Read data stands only in the answer cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && penable && !pready && !pwrite)
         prdata <= next_rdata;
      else if (rd_en)
         prdata <= 32'h00000000;
   end
endmodule

// [verification/abu_props.sv]
// Concurrent checks on the ports of the address breakpoint unit
`timescale 1ns/10ps
module abu_props
(
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        monitor_mode,
   input wire        wait_mode,
   input wire        stop_mode,
   input wire        cpu_last_cycle,
   input wire        cpu_break_taken,
   input wire        cpu_rti_done,
   input wire        break_request,
   input wire        break_state,
   input wire        timer_hold,
   input wire        watchdog_hold,
   input wire        halt_wakeup,
   input wire        status_clear_allow,
   input wire        test_high_voltage,
   input wire [7:0]  soft_interrupt_opcode,
   input wire [15:0] break_vector
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ack; psel && penable && !pready |=> pready; endproperty
   a_ack: assert property (p_ack) else $error("no ready on second access cycle");
   property p_drop; cpu_break_taken |=> !break_request; endproperty
   a_drop: assert property (p_drop) else $error("request kept after break taken");
   property p_enter; cpu_break_taken |=> break_state; endproperty
   a_enter: assert property (p_enter) else $error("break state not entered");
   property p_end; break_state && cpu_rti_done |-> ##[1:2] !break_state; endproperty
   a_end: assert property (p_end) else $error("break state kept after return");
   property p_wait; $rose(break_request) |-> $past(cpu_last_cycle) || $past(wait_mode) || $past(stop_mode); endproperty
   a_wait: assert property (p_wait) else $error("request before instruction end");
   property p_hold; break_state |-> timer_hold; endproperty
   a_hold: assert property (p_hold) else $error("timers run in break");
   property p_wdog; watchdog_hold |-> timer_hold && ($past(test_high_voltage, 2) || $past(test_high_voltage, 3)); endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog held wrongly");
   property p_clr; !break_state [*3] |-> status_clear_allow; endproperty
   a_clr: assert property (p_clr) else $error("flag clear blocked outside break");
   property p_vec; monitor_mode [*4] |=> break_vector == 16'hFEFC; endproperty
   a_vec: assert property (p_vec) else $error("monitor vector wrong");
   property p_op; $past(presetn) |-> soft_interrupt_opcode == 8'h83; endproperty
   a_op: assert property (p_op) else $error("opcode wrong");
   property p_wake; halt_wakeup |-> $past(break_request) && ($past(wait_mode) || $past(stop_mode)); endproperty
   a_wake: assert property (p_wake) else $error("wakeup without halted break");
endmodule

// [verification/abu_cpu_model.sv]
// Behavioural model of the CPU core facing the breakpoint unit
`timescale 1ns/10ps
module abu_cpu_model
(
   input  wire pclk,
   input  wire presetn,
   input  wire break_request,
   input  wire break_state,
   output reg  cpu_last_cycle,
   output reg  cpu_break_taken,
   output reg  cpu_rti_done
);
   reg [4:0] cnt;
   reg [4:0] bcnt;
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt             <= 5'h00;
         bcnt            <= 5'h00;
         cpu_last_cycle  <= 1'b0;
         cpu_break_taken <= 1'b0;
         cpu_rti_done    <= 1'b0;
      end
      else
      begin
         cnt             <= cnt + 5'h01;
         bcnt            <= break_state ? bcnt + 5'h01 : 5'h00;
         cpu_last_cycle  <= cnt[1:0] == 2'h2;
         cpu_break_taken <= break_request & ~cpu_break_taken & cnt[0];
         cpu_rti_done    <= break_state & (bcnt == 5'h1E);
      end
endmodule

// [verification/tb.sv]
// Testbench of the address breakpoint unit
`timescale 1ns/10ps
module tb;
   reg         pclk, presetn, psel, penable, pwrite, mon, wt, st, thv, av, er;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [15:0] ca;
   wire [31:0] prdata;
   wire        pready, pslverr, lc, tk, rt, req, bs, th, wh, sca, hw;
   wire [15:0] vec;
   wire [7:0]  op;
   integer     error_cnt, check_count, n, k;
   abu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_addr(ca),
      .cpu_addr_valid(av), .cpu_last_cycle(lc), .cpu_break_taken(tk), .cpu_rti_done(rt), .monitor_mode(mon),
      .wait_mode(wt), .stop_mode(st), .test_high_voltage(thv), .break_request(req), .soft_interrupt_opcode(op),
      .break_vector(vec), .break_state(bs), .timer_hold(th), .watchdog_hold(wh), .halt_wakeup(hw),
      .status_clear_allow(sca));
   abu_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .break_request(req), .break_state(bs),
      .cpu_last_cycle(lc), .cpu_break_taken(tk), .cpu_rti_done(rt));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp)
         begin
            error_cnt = error_cnt + 1;
            $display("Error %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [7:0] d);
      begin
         psel    <= 1'b1;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= {24'h000000, d};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         rd = prdata;
         er = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task till(input [1:0] s);
      begin
         k = 0;
         while (k < 60 && {bs, req} !== s)
         begin
            @(posedge pclk);
            k = k + 1;
         end
         chk({bs, req}, s);
      end
   endtask
   task t_reset;
      begin
         for (n = 0; n < 5; n = n + 1)
         begin
            apb(1'b0, {n[9:0], 2'b00}, 8'h00);
            chk(rd, 32'h0);
         end
         apb(1'b1, 12'h014, 8'hFF);
         chk(er, 1'b1);
      end
   endtask
   task t_match;
      begin
         apb(1'b1, 12'h004, 8'h12);
         apb(1'b1, 12'h008, 8'h34);
         apb(1'b0, 12'h004, 8'h00);
         chk(rd, 32'h12);
         apb(1'b1, 12'h000, 8'h80);
         ca <= 16'h1234;
         @(posedge pclk);
         ca <= 16'h0000;
         till(2'b01);
         till(2'b10);
         chk(th, 1'b1);
         chk(wh, 1'b0);
         apb(1'b0, 12'h000, 8'h00);
         chk(rd, 32'hC0);
         chk(sca, 1'b0);
         apb(1'b1, 12'h000, 8'h80);
         till(2'b00);
      end
   endtask
   task t_nomatch;
      begin
         apb(1'b1, 12'h000, 8'h00);
         ca <= 16'h1234;
         repeat (10) @(posedge pclk);
         ca <= 16'h0000;
         chk(req, 1'b0);
         apb(1'b1, 12'h000, 8'h80);
         av <= 1'b0;
         ca <= 16'h1234;
         repeat (10) @(posedge pclk);
         chk(req, 1'b0);
         ca <= 16'h0000;
         av <= 1'b1;
         apb(1'b0, 12'h000, 8'h00);
         chk(rd, 32'h80);
         apb(1'b1, 12'h000, 8'h00);
      end
   endtask
   task t_wait;
      begin
         apb(1'b1, 12'h010, 8'h80);
         wt <= 1'b1;
         apb(1'b1, 12'h000, 8'h40);
         till(2'b01);
         @(posedge pclk);
         chk(hw, 1'b1);
         till(2'b10);
         wt <= 1'b0;
         apb(1'b0, 12'h00C, 8'h00);
         chk(rd, 32'h2);
         chk(sca, 1'b1);
         apb(1'b1, 12'h00C, 8'h00);
         apb(1'b0, 12'h00C, 8'h00);
         chk(rd, 32'h0);
         apb(1'b1, 12'h000, 8'h00);
         till(2'b00);
      end
   endtask
   task t_stop;
      begin
         apb(1'b1, 12'h010, 8'h00);
         st  <= 1'b1;
         thv <= 1'b1;
         mon <= 1'b1;
         apb(1'b1, 12'h000, 8'h40);
         till(2'b10);
         st  <= 1'b0;
         apb(1'b0, 12'h00C, 8'h00);
         chk(rd, 32'h2);
         chk(wh, 1'b1);
         chk(vec, 32'hFEFC);
         chk(op, 32'h83);
         apb(1'b1, 12'h00C, 8'h00);
         apb(1'b1, 12'h000, 8'h00);
         till(2'b00);
         thv <= 1'b0;
         mon <= 1'b0;
      end
   endtask
   task conclude;
      begin
         $display("errors %0d checks %0d", error_cnt, check_count);
         if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial
   begin
      #300000;
      error_cnt = error_cnt + 1;
      conclude;
   end
   initial
   begin
      {presetn, psel, penable, pwrite, mon, wt, st, thv} = 8'h00;
      av = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      ca = 16'h0000;
      error_cnt = 0;
      check_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_match;
      t_nomatch;
      t_wait;
      t_stop;
      conclude;
   end
endmodule
bind abu_top abu_props i_props (.*);
